// >>> hdl/cpu_prog_regs.sv
// cpu programming-model registers with a register-bus debug view
`timescale 1ns/10ps
module cpu_prog_regs (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_sys_rst,
  input  wire cpu_regs_pkg::seq_ctrl_t i_ctrl,
  output cpu_regs_pkg::cpu_view_t      o_view,
  input  wire cpu_regs_pkg::axil_req_t i_axil,
  output cpu_regs_pkg::axil_rsp_t      o_axil
);
  // ==========================================================================
  // state
  cpu_regs_pkg::state_t q;
  cpu_regs_pkg::state_t d;
  logic [8:0]           add_sum;
  logic [4:0]           add_half;
  logic                 wr_fire;
  logic [7:0]           wr_word;
  logic [7:0]           rd_word;

  // add path shared by the flag logic and its checks
  assign add_sum  = {1'b0, i_ctrl.alu_a} + {1'b0, i_ctrl.alu_b} + {8'h00, i_ctrl.alu_cin};
  assign add_half = {1'b0, i_ctrl.alu_a[3:0]} + {1'b0, i_ctrl.alu_b[3:0]} + {4'h0, i_ctrl.alu_cin};
  assign wr_fire  = q.aw_got && q.w_got && !q.rsp.bvalid;
  assign wr_word  = {q.awaddr[7:2], 2'b00};
  assign rd_word  = {i_axil.araddr[7:2], 2'b00};

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    // condition flags from the alu result
    unique case (i_ctrl.flag_op)
      cpu_regs_pkg::FLG_NONE: begin
      end
      cpu_regs_pkg::FLG_ADD: begin
        d.flags[cpu_regs_pkg::CCR_H] = add_half[4];
        d.flags[cpu_regs_pkg::CCR_C] = add_sum[8];
        d.flags[cpu_regs_pkg::CCR_N] = add_sum[7];
        d.flags[cpu_regs_pkg::CCR_Z] = (add_sum[7:0] == 8'h00);
      end
      cpu_regs_pkg::FLG_ARITH, cpu_regs_pkg::FLG_SHIFT: begin
        d.flags[cpu_regs_pkg::CCR_C] = i_ctrl.alu_cout;
        d.flags[cpu_regs_pkg::CCR_N] = i_ctrl.alu_res[7];
        d.flags[cpu_regs_pkg::CCR_Z] = (i_ctrl.alu_res == 8'h00);
      end
      cpu_regs_pkg::FLG_LOGIC, cpu_regs_pkg::FLG_LOAD, cpu_regs_pkg::FLG_INCDEC: begin
        // carry untouched here, which is what inc and dec need
        d.flags[cpu_regs_pkg::CCR_N] = i_ctrl.alu_res[7];
        d.flags[cpu_regs_pkg::CCR_Z] = (i_ctrl.alu_res == 8'h00);
      end
      cpu_regs_pkg::FLG_BTB: begin
        d.flags[cpu_regs_pkg::CCR_C] = i_ctrl.alu_cout;
      end
    endcase
    // mask: a return restores the whole set, interrupt entry wins over clear
    if (i_ctrl.ccr_restore) begin
      d.flags = i_ctrl.ccr_wdata[4:0];
    end else if (i_ctrl.mask_set) begin
      d.flags[cpu_regs_pkg::CCR_I] = 1'b1;
    end else if (i_ctrl.mask_clr) begin
      d.flags[cpu_regs_pkg::CCR_I] = 1'b0;
    end
    // accumulator and index; the sequencer beats a bus write in the same cycle
    if (i_ctrl.acc_we) begin
      d.acc = i_ctrl.acc_wdata;
    end else if (wr_fire && wr_word == cpu_regs_pkg::OFF_ACC && q.wstrb[0]) begin
      d.acc = q.wdata[7:0];
    end
    if (i_ctrl.idx_we) begin
      d.idx = i_ctrl.idx_wdata;
    end else if (wr_fire && wr_word == cpu_regs_pkg::OFF_IDX && q.wstrb[0]) begin
      d.idx = q.wdata[7:0];
    end
    // six-bit pointer: modular arithmetic gives the wrap for free
    if (i_ctrl.stack_rst) begin
      d.sp = cpu_regs_pkg::SP_RESET;
    end else if (i_ctrl.push && !i_ctrl.pull) begin
      d.sp = q.sp - 6'h01;
    end else if (i_ctrl.pull && !i_ctrl.push) begin
      d.sp = q.sp + 6'h01;
    end
    // program counter: a load beats an increment, bus writes come last
    if (i_ctrl.pc_load) begin
      d.pc = i_ctrl.pc_wdata;
    end else if (i_ctrl.pc_inc) begin
      d.pc = q.pc + 16'h0001;
    end else if (wr_fire && wr_word == cpu_regs_pkg::OFF_PC) begin
      if (q.wstrb[0]) begin
        d.pc[7:0] = q.wdata[7:0];
      end
      if (q.wstrb[1]) begin
        d.pc[15:8] = q.wdata[15:8];
      end
    end
    // indexed address uses the index value before any write this cycle
    d.ea_valid = i_ctrl.ea_req;
    if (i_ctrl.ea_req) begin
      unique case (i_ctrl.ea_mode)
        cpu_regs_pkg::IDX_NONE: d.ea = {8'h00, q.idx};
        cpu_regs_pkg::IDX_OFF8: d.ea = {8'h00, q.idx} + {8'h00, i_ctrl.ea_offset[7:0]};
        cpu_regs_pkg::IDX_OFF16: d.ea = {8'h00, q.idx} + i_ctrl.ea_offset;
        default: d.ea = q.ea;
      endcase
    end
    // bus write channels, taken in either order
    if (q.rsp.awready && i_axil.awvalid) begin
      d.aw_got = 1'b1;
      d.awaddr = i_axil.awaddr;
    end
    if (q.rsp.wready && i_axil.wvalid) begin
      d.w_got = 1'b1;
      d.wdata = i_axil.wdata;
      d.wstrb = i_axil.wstrb;
    end
    if (q.rsp.bvalid && i_axil.bready) begin
      d.rsp.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_got     = 1'b0;
      d.w_got      = 1'b0;
      d.rsp.bvalid = 1'b1;
      case (wr_word)
        cpu_regs_pkg::OFF_ACC, cpu_regs_pkg::OFF_IDX, cpu_regs_pkg::OFF_PC,
        cpu_regs_pkg::OFF_STACK, cpu_regs_pkg::OFF_CCR: d.rsp.bresp = cpu_regs_pkg::RESP_OKAY;
        default: d.rsp.bresp = cpu_regs_pkg::RESP_SLVERR;
      endcase
    end
    // read channel, one outstanding read
    if (q.rsp.rvalid && i_axil.rready) begin
      d.rsp.rvalid = 1'b0;
    end
    if (q.rsp.arready && i_axil.arvalid) begin
      d.rsp.rvalid = 1'b1;
      d.rsp.rresp  = cpu_regs_pkg::RESP_OKAY;
      case (rd_word)
        cpu_regs_pkg::OFF_ACC: d.rsp.rdata = {24'h000000, q.acc};
        cpu_regs_pkg::OFF_IDX: d.rsp.rdata = {24'h000000, q.idx};
        cpu_regs_pkg::OFF_STACK: d.rsp.rdata = {16'h0000, cpu_regs_pkg::STACK_HI, q.sp};
        cpu_regs_pkg::OFF_PC: d.rsp.rdata = {16'h0000, q.pc};
        cpu_regs_pkg::OFF_CCR: d.rsp.rdata = {24'h000000, cpu_regs_pkg::CCR_ONES, q.flags};
        default: begin
          d.rsp.rdata = 32'h00000000;
          d.rsp.rresp = cpu_regs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // ready falls while a response waits so nothing is taken twice
    d.rsp.awready = !d.aw_got && !d.rsp.bvalid;
    d.rsp.wready  = !d.w_got && !d.rsp.bvalid;
    d.rsp.arready = !d.rsp.rvalid;
    // reset leaves data and result flags alone, only control state moves
    if (i_sys_rst) begin
      d.acc      = q.acc;
      d.idx      = q.idx;
      d.flags    = q.flags;
      d.flags[cpu_regs_pkg::CCR_I] = 1'b1;
      d.sp       = cpu_regs_pkg::SP_RESET;
      d.pc       = cpu_regs_pkg::PC_RESET;
      d.ea       = 16'h0000;
      d.ea_valid = 1'b0;
      d.aw_got   = 1'b0;
      d.w_got    = 1'b0;
      d.awaddr   = 8'h00;
      d.wdata    = 32'h00000000;
      d.wstrb    = 4'h0;
      d.rsp      = '0;
      d.rsp.awready = 1'b1;
      d.rsp.wready  = 1'b1;
      d.rsp.arready = 1'b1;
    end
  end

  // single register stage for the whole state
  always_ff @(posedge i_ref_clk) begin
    q <= d;
  end

  // ==========================================================================
  // outputs
  // the stack address names the next free byte, so a push writes here first
  assign o_view.acc        = q.acc;
  assign o_view.idx        = q.idx;
  assign o_view.stack_addr = {cpu_regs_pkg::STACK_HI, q.sp};
  assign o_view.pc         = q.pc;
  assign o_view.cond_code_reg        = {cpu_regs_pkg::CCR_ONES, q.flags};
  assign o_view.ea         = q.ea;
  assign o_view.ea_valid   = q.ea_valid;
  assign o_axil            = q.rsp;

  // ==========================================================================
  // checks
  sequence s_push_only;
    i_ctrl.push && !i_ctrl.pull && !i_ctrl.stack_rst;
  endsequence
  sequence s_pull_only;
    i_ctrl.pull && !i_ctrl.push && !i_ctrl.stack_rst;
  endsequence
  sequence s_flag_free;
    !i_ctrl.ccr_restore && !i_ctrl.mask_set && !i_ctrl.mask_clr;
  endsequence

  property p_stack_window;
    @(posedge i_ref_clk) o_view.stack_addr[15:6] == cpu_regs_pkg::STACK_HI;
  endproperty
  a_stack_window: assert property (p_stack_window) else $error("stack address left window");

  property p_sp_reset;
    @(posedge i_ref_clk) (i_sys_rst || i_ctrl.stack_rst) |=> (o_view.stack_addr == 16'h00FF);
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("stack pointer not reset to top");

  property p_push_dec;
    @(posedge i_ref_clk) disable iff (i_sys_rst) s_push_only |=> (q.sp == $past(q.sp) - 6'h01);
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not decrement");

  property p_pull_inc;
    @(posedge i_ref_clk) disable iff (i_sys_rst) s_pull_only |=> (q.sp == $past(q.sp) + 6'h01);
  endproperty
  a_pull_inc: assert property (p_pull_inc) else $error("pull did not increment");

  property p_push_wrap;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (s_push_only ##0 (o_view.stack_addr == 16'h00C0)) |=> (o_view.stack_addr == 16'h00FF);
  endproperty
  a_push_wrap: assert property (p_push_wrap) else $error("stack did not wrap at bottom");

  property p_five_push;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (s_push_only [*5]) |=> (q.sp == $past(q.sp, 5) - 6'h05);
  endproperty
  a_five_push: assert property (p_five_push) else $error("five pushes moved pointer wrongly");

  property p_reset_keeps;
    @(posedge i_ref_clk) i_sys_rst |=> ((q.acc === $past(q.acc)) && (q.idx === $past(q.idx)));
  endproperty
  a_reset_keeps: assert property (p_reset_keeps) else $error("reset altered data registers");

  property p_reset_ccr;
    @(posedge i_ref_clk) i_sys_rst |=> (o_view.cond_code_reg[3] && (o_view.cond_code_reg[4] === $past(q.flags[4]))
      && (o_view.cond_code_reg[2:0] === $past(q.flags[2:0])));
  endproperty
  a_reset_ccr: assert property (p_reset_ccr) else $error("reset handled condition codes wrongly");

  property p_mask_clr;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ctrl.mask_clr && !i_ctrl.mask_set && !i_ctrl.ccr_restore) |=> !o_view.cond_code_reg[3];
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared");

  property p_ccr_ones;
    @(posedge i_ref_clk) o_view.cond_code_reg[7:5] == 3'h7;
  endproperty
  a_ccr_ones: assert property (p_ccr_ones) else $error("condition code top bits not ones");

  property p_ea_none;
    @(posedge i_ref_clk) disable iff (i_sys_rst) (i_ctrl.ea_req && i_ctrl.ea_mode == cpu_regs_pkg::IDX_NONE)
      |=> (o_view.ea_valid && o_view.ea == {8'h00, $past(q.idx)});
  endproperty
  a_ea_none: assert property (p_ea_none) else $error("no-offset address wrong");

  property p_ea_off8;
    @(posedge i_ref_clk) disable iff (i_sys_rst) (i_ctrl.ea_req && i_ctrl.ea_mode == cpu_regs_pkg::IDX_OFF8)
      |=> (o_view.ea == {8'h00, $past(q.idx)} + {8'h00, $past(i_ctrl.ea_offset[7:0])});
  endproperty
  a_ea_off8: assert property (p_ea_off8) else $error("8-bit offset address wrong");

  property p_ea_off16;
    @(posedge i_ref_clk) disable iff (i_sys_rst) (i_ctrl.ea_req && i_ctrl.ea_mode == cpu_regs_pkg::IDX_OFF16)
      |=> (o_view.ea == {8'h00, $past(q.idx)} + $past(i_ctrl.ea_offset));
  endproperty
  a_ea_off16: assert property (p_ea_off16) else $error("16-bit offset address wrong");

  property p_pc_step;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_ctrl.pc_inc && !i_ctrl.pc_load) |=> (o_view.pc == $past(q.pc) + 16'h0001);
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("program counter did not step");

  property p_pc_load;
    @(posedge i_ref_clk) disable iff (i_sys_rst) i_ctrl.pc_load |=> (o_view.pc == $past(i_ctrl.pc_wdata));
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("program counter load lost");

  property p_half;
    @(posedge i_ref_clk) disable iff (i_sys_rst) ((i_ctrl.flag_op == cpu_regs_pkg::FLG_ADD) ##0 s_flag_free)
      |=> (o_view.cond_code_reg[4] == $past(add_half[4]));
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");

  property p_neg;
    @(posedge i_ref_clk) disable iff (i_sys_rst) ((i_ctrl.flag_op == cpu_regs_pkg::FLG_LOGIC) ##0 s_flag_free)
      |=> (o_view.cond_code_reg[2] == $past(i_ctrl.alu_res[7]));
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");

  property p_zero;
    @(posedge i_ref_clk) disable iff (i_sys_rst) ((i_ctrl.flag_op == cpu_regs_pkg::FLG_LOAD) ##0 s_flag_free)
      |=> (o_view.cond_code_reg[1] == ($past(i_ctrl.alu_res) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_carry_kept;
    @(posedge i_ref_clk) disable iff (i_sys_rst) ((i_ctrl.flag_op == cpu_regs_pkg::FLG_INCDEC) ##0 s_flag_free)
      |=> (o_view.cond_code_reg[0] == $past(q.flags[0]));
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("inc or dec touched carry");
endmodule : cpu_prog_regs

// >>> hdl/cpu_regs_pkg.sv
// constants and carrier types for the cpu programming-model register set
package cpu_regs_pkg;
  // ==========================================================================
  // stack, program counter and condition codes
  localparam logic [9:0]  STACK_HI   = 10'h003;
  localparam logic [5:0]  SP_RESET   = 6'h3F;
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [2:0]  CCR_ONES   = 3'h7;
  localparam int          CCR_H      = 4;
  localparam int          CCR_I      = 3;
  localparam int          CCR_N      = 2;
  localparam int          CCR_Z      = 1;
  localparam int          CCR_C      = 0;
  // ==========================================================================
  // register bus map, byte addresses
  localparam logic [7:0]  OFF_ACC    = 8'h00;
  localparam logic [7:0]  OFF_IDX    = 8'h04;
  localparam logic [7:0]  OFF_STACK  = 8'h08;
  localparam logic [7:0]  OFF_PC     = 8'h0C;
  localparam logic [7:0]  OFF_CCR    = 8'h10;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    FLG_NONE, FLG_ADD, FLG_ARITH, FLG_LOGIC, FLG_LOAD, FLG_INCDEC, FLG_SHIFT, FLG_BTB
  } flag_op_t;
  typedef enum logic [1:0] {IDX_NONE, IDX_OFF8, IDX_OFF16} idx_mode_t;
  typedef struct packed {
    logic        acc_we;
    logic [7:0]  acc_wdata;
    logic        idx_we;
    logic [7:0]  idx_wdata;
    logic        push;
    logic        pull;
    logic        stack_rst;
    logic        pc_inc;
    logic        pc_load;
    logic [15:0] pc_wdata;
    flag_op_t    flag_op;
    logic [7:0]  alu_a;
    logic [7:0]  alu_b;
    logic        alu_cin;
    logic [7:0]  alu_res;
    logic        alu_cout;
    logic        mask_set;
    logic        mask_clr;
    logic        ccr_restore;
    logic [7:0]  ccr_wdata;
    logic        ea_req;
    idx_mode_t   ea_mode;
    logic [15:0] ea_offset;
  } seq_ctrl_t;
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [15:0] stack_addr;
    logic [15:0] pc;
    logic [7:0]  cond_code_reg;
    logic [15:0] ea;
    logic        ea_valid;
  } cpu_view_t;
  typedef struct packed {
    logic [7:0]  awaddr;
    logic [2:0]  awprot;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic [2:0]  arprot;
    logic        arvalid;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  idx;
    logic [5:0]  sp;
    logic [15:0] pc;
    logic [4:0]  flags;
    logic [15:0] ea;
    logic        ea_valid;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    axil_rsp_t   rsp;
  } state_t;
endpackage : cpu_regs_pkg

// >>> tb/seq_model.sv
// sequencer and alu model that drives the control word of the register set
`timescale 1ns/10ps
module seq_model (
  input  wire logic               i_ref_clk,
  output cpu_regs_pkg::seq_ctrl_t o_ctrl
);
  // ==========================================================================
  // control word drive
  initial begin
    o_ctrl = '0;
  end
  // the alu result is formed here, as a real datapath would hand it over
  task automatic issue(input cpu_regs_pkg::seq_ctrl_t c);
    logic [8:0] s;
    s = {1'b0, c.alu_a} + {1'b0, c.alu_b} + {8'h00, c.alu_cin};
    c.alu_res = s[7:0];
    c.alu_cout = s[8];
    @(posedge i_ref_clk);
    o_ctrl <= c;
  endtask : issue
  // idle word; a field left high would repeat its action every cycle
  task automatic rest();
    @(posedge i_ref_clk);
    o_ctrl <= '0;
  endtask : rest
endmodule : seq_model

// >>> tb/cpu_programming_model_regs_tb.sv
// self-checking bench for the cpu programming-model register set
`timescale 1ns/10ps
module cpu_programming_model_regs_tb;
  // ==========================================================================
  // signals
  logic                    ref_clk;
  logic                    sys_rst;
  cpu_regs_pkg::seq_ctrl_t ctrl;
  cpu_regs_pkg::cpu_view_t view;
  cpu_regs_pkg::axil_req_t req;
  cpu_regs_pkg::axil_rsp_t rsp;
  cpu_regs_pkg::seq_ctrl_t c;
  logic [33:0]             exp_q[$];
  logic [33:0]             ea_q[$];
  logic [8:0]              s;
  logic [15:0]             e;
  logic [15:0]             pc_e;
  logic [7:0]              x;
  logic [5:0]              sp_e;
  logic [31:0]             d;
  logic                    h_f, i_f, n_f, z_f, c_f;
  int                      seed;
  int                      k;
  int                      err_count;
  int                      total_checks;
  int                      cyc_cnt;
  seq_model i_seq (
    .i_ref_clk (ref_clk),
    .o_ctrl    (ctrl)
  );
  cpu_prog_regs i_dut (
    .i_ref_clk (ref_clk),
    .i_sys_rst (sys_rst),
    .i_ctrl    (ctrl),
    .o_view    (view),
    .i_axil    (req),
    .o_axil    (rsp)
  );
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // helpers
  function automatic logic [33:0] ok(input logic [31:0] v);
    return {cpu_regs_pkg::RESP_OKAY, v};
  endfunction : ok
  function automatic logic [33:0] ccr_exp();
    return ok({24'h0, 3'h7, h_f, i_f, n_f, z_f, c_f});
  endfunction : ccr_exp
  task automatic check(input string what, input logic [33:0] ex, input logic [33:0] got);
    total_checks++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, ex, got);
    end
  endtask : check
  task automatic end_sim();
    if (exp_q.size() != 0 || ea_q.size() != 0) err_count++;
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic do_reset();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : do_reset
  // each channel is released at the edge that takes it
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= st;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, input logic [33:0] ex);
    exp_q.push_back(ex);
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    @(posedge ref_clk);
    while (!rsp.arready) @(posedge ref_clk);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge ref_clk);
    req.rready <= 1'b0;
  endtask : bus_rd
  // ==========================================================================
  // result watcher: oldest note is compared whenever an answer appears
  always @(posedge ref_clk) begin
    if (rsp.rvalid && req.rready) check("read", exp_q.pop_front(), {rsp.rresp, rsp.rdata});
    if (rsp.bvalid && req.bready) check("write", exp_q.pop_front(), {rsp.bresp, 32'h0});
    if (view.ea_valid) check("ea", ea_q.pop_front(), {18'h0, view.ea});
  end
  // hang guard; the whole run needs a few hundred cycles
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    seed = 32'h63CE889A;
    sys_rst = 1'b1;
    req = '0;
    err_count = 0;
    total_checks = 0;
    cyc_cnt = 0;
    sp_e = 6'h3F;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    i_f = 1'b1;
    // every flag mode except FLG_NONE, the add first so all flags become defined
    repeat (3) begin
      for (k = 1; k < 8; k++) begin
        c = '0;
        c.flag_op = cpu_regs_pkg::flag_op_t'(k);
        c.alu_a = 8'($random(seed));
        c.alu_b = 8'($random(seed));
        c.alu_cin = 1'($random(seed));
        s = {1'b0, c.alu_a} + {1'b0, c.alu_b} + {8'h00, c.alu_cin};
        if (k == 1) h_f = ({1'b0, c.alu_a[3:0]} + {1'b0, c.alu_b[3:0]} + {4'h0, c.alu_cin}) > 5'h0F;
        if (k != 3 && k != 4 && k != 5) c_f = s[8];
        if (k != 7) n_f = s[7];
        if (k != 7) z_f = (s[7:0] == 8'h00);
        i_seq.issue(c);
        i_seq.rest();
        bus_rd(cpu_regs_pkg::OFF_CCR, ccr_exp());
      end
    end
    // interrupt mask: clear, set beats clear, restore beats both
    c = '0;
    c.mask_clr = 1'b1;
    i_seq.issue(c);
    i_seq.rest();
    i_f = 1'b0;
    bus_rd(cpu_regs_pkg::OFF_CCR, ccr_exp());
    c.mask_set = 1'b1;
    i_seq.issue(c);
    i_seq.rest();
    i_f = 1'b1;
    bus_rd(cpu_regs_pkg::OFF_CCR, ccr_exp());
    c.ccr_restore = 1'b1;
    c.ccr_wdata = 8'($random(seed));
    i_seq.issue(c);
    i_seq.rest();
    {h_f, i_f, n_f, z_f, c_f} = c.ccr_wdata[4:0];
    bus_rd(cpu_regs_pkg::OFF_CCR, ccr_exp());
    c = '0;
    c.mask_clr = 1'b1;
    i_seq.issue(c);
    i_f = 1'b0;
    // stack: 64 pushes, with reads after the 1st, 63rd and 64th, come round to the top again
    c = '0;
    c.push = 1'b1;
    for (k = 0; k < 64; k++) begin
      i_seq.issue(c);
      sp_e = sp_e - 6'h01;
      if (k == 0 || k == 62 || k == 63) begin
        i_seq.rest();
        bus_rd(cpu_regs_pkg::OFF_STACK, ok({16'h0, 10'h003, sp_e}));
      end
    end
    c.pull = 1'b1;
    i_seq.issue(c);
    c.push = 1'b0;
    i_seq.issue(c);
    i_seq.rest();
    bus_rd(cpu_regs_pkg::OFF_STACK, ok(32'h0000_00C0));
    bus_wr(cpu_regs_pkg::OFF_STACK, 32'h0000_0000, 4'hF, cpu_regs_pkg::RESP_OKAY);
    c.stack_rst = 1'b1;
    i_seq.issue(c);
    i_seq.rest();
    bus_rd(cpu_regs_pkg::OFF_STACK, ok(32'h0000_00FF));
    // program counter: load beats increment, then wrap through zero
    c = '0;
    c.pc_load = 1'b1;
    c.pc_inc = 1'b1;
    c.pc_wdata = 16'hFFFD;
    i_seq.issue(c);
    c = '0;
    c.pc_inc = 1'b1;
    repeat (4) i_seq.issue(c);
    i_seq.rest();
    bus_rd(cpu_regs_pkg::OFF_PC, ok(32'h0000_0001));
    d = 32'($random(seed));
    bus_wr(cpu_regs_pkg::OFF_PC, d, 4'h1, cpu_regs_pkg::RESP_OKAY);
    bus_rd(cpu_regs_pkg::OFF_PC, ok({24'h0, d[7:0]}));
    // indexed addresses in all three modes
    for (k = 0; k < 9; k++) begin
      x = 8'($random(seed));
      c = '0;
      c.idx_we = 1'b1;
      c.idx_wdata = x;
      i_seq.issue(c);
      c = '0;
      c.ea_req = 1'b1;
      c.ea_mode = cpu_regs_pkg::idx_mode_t'(k % 3);
      c.ea_offset = 16'($random(seed));
      if (k % 3 == 0) e = {8'h00, x};
      if (k % 3 == 1) e = {8'h00, x} + {8'h00, c.ea_offset[7:0]};
      if (k % 3 == 2) e = {8'h00, x} + c.ea_offset;
      ea_q.push_back({18'h0, e});
      i_seq.issue(c);
      i_seq.rest();
    end
    // mid-run reset keeps accumulator, index and result flags
    d = 32'($random(seed));
    bus_wr(cpu_regs_pkg::OFF_ACC, d, 4'hF, cpu_regs_pkg::RESP_OKAY);
    do_reset();
    i_f = 1'b1;
    bus_rd(cpu_regs_pkg::OFF_ACC, ok({24'h0, d[7:0]}));
    bus_rd(cpu_regs_pkg::OFF_IDX, ok({24'h0, x}));
    bus_rd(cpu_regs_pkg::OFF_CCR, ccr_exp());
    bus_rd(cpu_regs_pkg::OFF_STACK, ok(32'h0000_00FF));
    bus_rd(cpu_regs_pkg::OFF_PC, ok(32'h0000_0000));
    // read-only and unmapped places
    bus_wr(cpu_regs_pkg::OFF_CCR, 32'h0000_0000, 4'hF, cpu_regs_pkg::RESP_OKAY);
    bus_rd(cpu_regs_pkg::OFF_CCR, ccr_exp());
    bus_rd(8'h14, {cpu_regs_pkg::RESP_SLVERR, 32'h0});
    bus_wr(8'h20, 32'($random(seed)), 4'hF, cpu_regs_pkg::RESP_SLVERR);
    repeat (4) @(posedge ref_clk);
    end_sim();
  end
endmodule : cpu_programming_model_regs_tb
